// File: logic/psid_consts.svh
// register offsets, field positions, reset values and nibble indices of the init sequencer
`ifndef PSID_CONSTS_SVH
`define PSID_CONSTS_SVH
// register byte addresses
`define PSID_ADR_CTRL       6'h00
`define PSID_ADR_TIMING2    6'h04
`define PSID_ADR_USERA      6'h08
`define PSID_ADR_USERB      6'h0c
`define PSID_ADR_SERIAL     6'h10
`define PSID_ADR_SERPART    6'h14
`define PSID_ADR_RESULT     6'h18
`define PSID_ADR_STATUS     6'h1c
`define PSID_ADR_MASK       6'h20
// control register fields, timing2 select bit and reset value (retry limit 3, repetition 4)
`define PSID_CTRL_RST       32'h0000_0430
`define PSID_CTRL_EXT       0
`define PSID_CTRL_ASYNC     1
`define PSID_CTRL_RETRY     4
`define PSID_CTRL_REP       8
`define PSID_T2_SEL19       0
// nibble indices of the second init phase, reserved nibble value and last ready flag value
`define PSID_NIB_FIRST      6'h0a
`define PSID_NIB_SEL19      6'h13
`define PSID_NIB_SEL20      6'h14
`define PSID_NIB_SER_END    6'h1c
`define PSID_NIB_STD_LAST   6'h20
`define PSID_NIB_RES_FIRST  6'h21
`define PSID_NIB_RES_SECOND 6'h22
`define PSID_NIB_RES_END    6'h28
`define PSID_NIB_EXT_LAST   6'h30
`define PSID_RSVD_VALUE     4'h0
`define PSID_READY_LAST     1'h1
// sticky status bits
`define PSID_STS_P2DONE     0
`define PSID_STS_PASS       1
`define PSID_STS_FAIL       2
`define PSID_STS_INITDONE   3
`define PSID_STS_W          4
`endif

// File: logic/psid_pkg.sv
// types of the init sequencer
package psid_pkg;
	// main sequencer states
	typedef enum logic [5:0] {
		SEQ_IDLE = 6'b000001,
		SEQ_ID   = 6'b000010,
		SEQ_DATA = 6'b000100,
		SEQ_PH3  = 6'b001000,
		SEQ_DONE = 6'b010000,
		SEQ_WAIT = 6'b100000
	} psid_seq_t;
	// self-test controller states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_END  = 3'b100
	} psid_st_t;
	// kind of one outgoing transmission
	typedef enum logic [1:0] {
		TX_ID    = 2'h0,
		TX_DATA  = 2'h1,
		TX_BUSY  = 2'h2,
		TX_READY = 2'h3
	} psid_tx_t;
endpackage : psid_pkg

// File: logic/psid_selftest.sv
// self-test run controller with bounded retries
`timescale 1ns/1ns
module psid_selftest #(
	parameter int RETRY_W = 4
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               start,      // one-cycle start request
	input  wire logic [RETRY_W-1:0] retryLimit, // further runs allowed after a failure
	input  wire logic               runDone,    // core finished one run
	input  wire logic               runPass,    // result of that run
	output logic                    runReq,     // one-cycle request for a run
	output logic                    done,       // self-test finished
	output logic                    passed,     // finished with a pass
	output logic [RETRY_W-1:0]      retries     // retries used so far
);
	import psid_pkg::*;

	if (RETRY_W < 1 || RETRY_W > 8) begin : g_chk
		$error("psid_selftest: RETRY_W out of range");
	end

	psid_st_t          state_q;   // controller state
	logic              req_q;     // run request pulse
	logic              pass_q;    // final verdict
	logic [RETRY_W-1:0] retry_q;  // retries used

	// run, check, retry or stop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			req_q   <= 1'b0;
			pass_q  <= 1'b0;
			retry_q <= '0;
		end else begin
			req_q <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					if (start) begin
						req_q   <= 1'b1;
						state_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (runDone && runPass) begin
						// first pass ends the test, no more runs
						pass_q  <= 1'b1; // RULE14
						state_q <= ST_END;
					end else if (runDone && retry_q == retryLimit) begin
						// out of retries, keep the fail
						state_q <= ST_END;
					end else if (runDone) begin
						// failed run is repeated while retries remain
						retry_q <= retry_q + 1'b1; // RULE13
						req_q   <= 1'b1;
					end
				end
				ST_END: begin
					// stays here until reset
					state_q <= ST_END;
				end
			endcase
		end
	end

	assign runReq  = req_q;
	assign done    = (state_q == ST_END);
	assign passed  = pass_q;
	assign retries = retry_q;

	sequence failWithRoom;
		state_q == ST_RUN && runDone && !runPass && retry_q != retryLimit;
	endsequence

	retry_run_a: assert property (@(posedge clk) disable iff (rst) // RULE13
		failWithRoom |=> runReq && retries == $past(retry_q) + 1'b1)
		else $error("failed run not retried");

	pass_stop_a: assert property (@(posedge clk) disable iff (rst) // RULE14
		(state_q == ST_RUN && runDone && runPass) |=> done && passed && !runReq [*3])
		else $error("self-test went on after a pass");
endmodule : psid_selftest

// File: logic/psid_sequencer.sv
// init phase 2 and 3 sequencer with self-test control and wishbone registers
//
// Operation
// RULE1 - each nibble sent as id then data, k times
// RULE2 - 32 nibbles, or 48 with extended phase 2
// RULE3 - fixed map of user, serial, part nibbles
// RULE4 - nibbles 19 and 20 chosen by select bit
// RULE5 - nibbles 33 to 40 carry self-test results
// RULE6 - first-run pass gives final results there
// RULE7 - unfinished test sends latest available values
// RULE8 - exhausted retries send last failed data
// RULE9 - async mode never waits for self-test
// RULE10 - async extended mode zeroes nibbles 33, 34
// RULE11 - reserved nibbles carry a constant value
// RULE12 - self-test starts when phase 1 ends
// RULE13 - failed self-test retried up to limit
// RULE14 - first pass ends self-test, no retries
// RULE15 - busy messages while self-test still runs
// RULE16 - exactly two ready messages after self-test
// RULE17 - done flag set on leaving phase 3
`timescale 1ns/1ns
`include "psid_consts.svh"
module psid_sequencer #(
	parameter int RETRY_W = 4
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [5:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        phase1Done,   // core finished phase 1
	output logic             stRunReq,     // start one self-test run
	input  wire logic        stRunDone,    // run finished, results valid
	input  wire logic        stRunPass,    // run verdict
	input  wire logic [31:0] stResult,     // pos avg, pos offset, neg avg, neg offset
	output logic             txValid,      // transmission pending
	input  wire logic        txReady,      // framer takes it
	output psid_pkg::psid_tx_t txKind,     // id, data, busy or ready
	output logic [5:0]       txData,       // nibble index or data nibble
	output logic             initDoneFlag, // init finished
	output logic             irq           // level interrupt
);
	import psid_pkg::*;

	if (RETRY_W < 1 || RETRY_W > 4) begin : g_chk
		$error("psid_sequencer: RETRY_W must fit the control field");
	end

	logic [31:0] ctrl_q;       // ext, async, retry limit, repetition
	logic        sel19_q;      // timing_config_two select bit
	logic [31:0] userA_q;      // user bytes 7..4
	logic [15:0] userB_q;      // user byte E, user byte 8
	logic [31:0] serial_q;     // serial bytes 3..0
	logic [19:0] serPart_q;    // part nibble, part byte zero, serial byte four
	logic [31:0] result_q;     // latest self-test values
	logic [`PSID_STS_W-1:0] sts_q;  // sticky events
	logic [`PSID_STS_W-1:0] mask_q; // interrupt mask
	logic        ack_q;        // bus answer
	logic [31:0] rdat_q;       // bus read data
	psid_seq_t   state_q;      // sequencer state
	logic [5:0]  nib_q;        // current nibble index
	logic [5:0]  last_q;       // last nibble of phase 2
	logic [3:0]  rep_q;        // repetition counter
	logic [3:0]  dataNib_q;    // data nibble caught at id accept
	logic        ready_q;      // one ready message already sent
	logic        done_q;       // init done flag
	logic        stStart;      // self-test start pulse
	logic        stDone;       // self-test finished
	logic        stPassed;     // self-test verdict
	logic        busWr;        // accepted write
	logic        busRd;        // accepted read
	logic        accept;       // transmission taken
	logic [3:0]  repLast;      // last repetition index
	logic [3:0]  nibVal;       // nibble content mux
	logic [`PSID_STS_W-1:0] stsSet; // events this cycle

	wire logic       extEn   = ctrl_q[`PSID_CTRL_EXT];
	wire logic       asyncEn = ctrl_q[`PSID_CTRL_ASYNC];
	wire logic [3:0] repCfg  = ctrl_q[`PSID_CTRL_REP +: 4];
	// self-test run control
	psid_selftest #(
		.RETRY_W(RETRY_W)
	) u_selftest (
		.clk       (clk),
		.rst       (rst),
		.start     (stStart),
		.retryLimit(ctrl_q[`PSID_CTRL_RETRY +: RETRY_W]),
		.runDone   (stRunDone),
		.runPass   (stRunPass),
		.runReq    (stRunReq),
		.done      (stDone),
		.passed    (stPassed),
		.retries   ()
	);
	// classic wishbone: one wait state, ack dropped after one cycle
	assign busWr = wb_cyc_i && wb_stb_i && !ack_q && wb_we_i;
	assign busRd = wb_cyc_i && wb_stb_i && !ack_q && !wb_we_i;
	// bus answer and read data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= busWr || busRd;
			if (busRd) begin
				unique case (wb_adr_i)
					`PSID_ADR_CTRL:    rdat_q <= ctrl_q;
					`PSID_ADR_TIMING2: rdat_q <= {31'h0000_0000, sel19_q};
					`PSID_ADR_USERA:   rdat_q <= userA_q;
					`PSID_ADR_USERB:   rdat_q <= {16'h0000, userB_q};
					`PSID_ADR_SERIAL:  rdat_q <= serial_q;
					`PSID_ADR_SERPART: rdat_q <= {12'h000, serPart_q};
					`PSID_ADR_RESULT:  rdat_q <= result_q;
					// live state above the sticky bits
					`PSID_ADR_STATUS:  rdat_q <= {19'h00000, stPassed, stDone, done_q, state_q, sts_q};
					`PSID_ADR_MASK:    rdat_q <= {28'h0000000, mask_q};
					default:           rdat_q <= 32'h0000_0000; // unmapped reads zero
				endcase
			end
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// software-written configuration, byte lanes honoured
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q    <= `PSID_CTRL_RST;
			sel19_q   <= 1'b0;
			userA_q   <= 32'h0000_0000;
			userB_q   <= 16'h0000;
			serial_q  <= 32'h0000_0000;
			serPart_q <= 20'h00000;
			mask_q    <= '0;
		end else if (busWr) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					unique case (wb_adr_i)
						`PSID_ADR_CTRL:   ctrl_q[b*8 +: 8]   <= wb_dat_i[b*8 +: 8];
						`PSID_ADR_USERA:  userA_q[b*8 +: 8]  <= wb_dat_i[b*8 +: 8];
						`PSID_ADR_SERIAL: serial_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
						default: ;
					endcase
				end
			end
			if (wb_sel_i[0]) begin
				unique case (wb_adr_i)
					`PSID_ADR_TIMING2: sel19_q <= wb_dat_i[`PSID_T2_SEL19];
					`PSID_ADR_USERB:   userB_q[7:0] <= wb_dat_i[7:0];
					`PSID_ADR_SERPART: serPart_q[7:0] <= wb_dat_i[7:0];
					`PSID_ADR_MASK:    mask_q <= wb_dat_i[`PSID_STS_W-1:0];
					default: ;
				endcase
			end
			if (wb_sel_i[1] && wb_adr_i == `PSID_ADR_USERB) begin
				userB_q[15:8] <= wb_dat_i[15:8];
			end
			if (wb_sel_i[1] && wb_adr_i == `PSID_ADR_SERPART) begin
				serPart_q[15:8] <= wb_dat_i[15:8];
			end
			if (wb_sel_i[2] && wb_adr_i == `PSID_ADR_SERPART) begin
				serPart_q[19:16] <= wb_dat_i[19:16];
			end
		end
	end

	// each finished run overwrites: a pass, a running test and an exhausted fail show the latest
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result_q <= 32'h0000_0000;
		end else if (stRunDone) begin
			result_q <= stResult; // RULE6 RULE7 RULE8
		end
	end

	// content of each phase 2 nibble
	always_comb begin
		nibVal = `PSID_RSVD_VALUE; // RULE11
		if (nib_q >= `PSID_NIB_RES_FIRST && nib_q <= `PSID_NIB_RES_END) begin
			// high nibble first through the four result bytes
			nibVal = result_q[{3'(`PSID_NIB_RES_END - nib_q), 2'h0} +: 4]; // RULE5
			if (asyncEn && extEn && nib_q <= `PSID_NIB_RES_SECOND) begin
				nibVal = 4'h0; // RULE10
			end
		end else if (nib_q > `PSID_NIB_SEL20 && nib_q <= `PSID_NIB_SER_END) begin
			nibVal = serial_q[{3'(`PSID_NIB_SER_END - nib_q), 2'h0} +: 4]; // RULE3
		end else begin
			unique case (nib_q)
				6'h0a: nibVal = userA_q[3:0]; // RULE3
				6'h0b: nibVal = userA_q[7:4];
				6'h0c: nibVal = userA_q[11:8];
				6'h0d: nibVal = userA_q[15:12];
				6'h0e: nibVal = userA_q[19:16];
				6'h0f: nibVal = userA_q[27:24];
				6'h10: nibVal = userA_q[31:28];
				6'h11: nibVal = userB_q[3:0];
				6'h12: nibVal = userB_q[7:4];
				// serial byte four or user data, by the select bit
				`PSID_NIB_SEL19: nibVal = sel19_q ? serPart_q[7:4] : userA_q[23:20]; // RULE4
				`PSID_NIB_SEL20: nibVal = sel19_q ? serPart_q[3:0] : userB_q[15:12]; // RULE4
				6'h1d: nibVal = serPart_q[19:16];
				6'h1e: nibVal = serPart_q[15:12];
				6'h1f: nibVal = serPart_q[11:8];
				6'h20: nibVal = userA_q[23:20];
				default: nibVal = `PSID_RSVD_VALUE;
			endcase
		end
	end

	assign repLast = (repCfg == 4'h0) ? 4'h0 : repCfg - 4'h1; // zero treated as one
	assign accept  = txValid && txReady;
	assign stStart = (state_q == SEQ_IDLE) && phase1Done; // RULE12

	// phase 2 pairs, then phase 3 busy and ready messages
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q   <= SEQ_IDLE;
			nib_q     <= `PSID_NIB_FIRST;
			last_q    <= `PSID_NIB_STD_LAST;
			rep_q     <= 4'h0;
			dataNib_q <= 4'h0;
			ready_q   <= 1'b0;
		end else begin
			unique case (state_q)
				SEQ_IDLE: begin
					if (phase1Done) begin
						// length fixed for the whole phase
						last_q  <= extEn ? `PSID_NIB_EXT_LAST : `PSID_NIB_STD_LAST; // RULE2
						state_q <= SEQ_ID;
					end
				end
				SEQ_ID: begin
					if (accept) begin
						// values caught here; no wait on self-test in any mode
						dataNib_q <= nibVal; // RULE9
						state_q   <= SEQ_DATA; // RULE1
					end
				end
				SEQ_DATA: begin
					if (accept && rep_q != repLast) begin
						rep_q   <= rep_q + 4'h1; // RULE1
						state_q <= SEQ_ID;
					end else if (accept && nib_q == last_q) begin
						rep_q   <= 4'h0;
						state_q <= SEQ_PH3; // RULE2
					end else if (accept) begin
						rep_q   <= 4'h0;
						nib_q   <= nib_q + 6'h01;
						state_q <= SEQ_ID;
					end
				end
				SEQ_PH3: begin
					if (accept && stDone) begin
						ready_q <= 1'b1;
						if (ready_q == `PSID_READY_LAST) begin
							state_q <= SEQ_DONE; // RULE16
						end
					end
				end
				SEQ_DONE: state_q <= SEQ_WAIT;
				SEQ_WAIT: state_q <= SEQ_WAIT;
				default:  state_q <= SEQ_IDLE;
			endcase
		end
	end

	// outgoing transmission
	assign txValid = (state_q == SEQ_ID) || (state_q == SEQ_DATA) || (state_q == SEQ_PH3);
	always_comb begin
		txKind = TX_ID;
		txData = nib_q;
		if (state_q == SEQ_DATA) begin
			txKind = TX_DATA;
			txData = {2'h0, dataNib_q};
		end else if (state_q == SEQ_PH3) begin
			txKind = stDone ? TX_READY : TX_BUSY; // RULE15
			txData = 6'h00;
		end
	end

	// flag set by the sequencer itself on leaving phase 3
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_q <= 1'b0;
		end else if (state_q == SEQ_DONE) begin
			done_q <= 1'b1; // RULE17
		end
	end
	assign initDoneFlag = done_q;

	// sticky events, cleared by a status read; a new event wins over the clear
	assign stsSet[`PSID_STS_P2DONE]   = (state_q == SEQ_DATA) && accept && rep_q == repLast && nib_q == last_q;
	assign stsSet[`PSID_STS_PASS]     = stRunDone && stRunPass;
	assign stsSet[`PSID_STS_FAIL]     = stRunDone && !stRunPass;
	assign stsSet[`PSID_STS_INITDONE] = (state_q == SEQ_DONE);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sts_q <= '0;
		end else if (busRd && wb_adr_i == `PSID_ADR_STATUS) begin
			sts_q <= stsSet;
		end else begin
			sts_q <= sts_q | stsSet;
		end
	end
	assign irq = |(sts_q & mask_q);

	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	sequence idTaken;
		state_q == SEQ_ID && txReady;
	endsequence
	pair_order_a: assert property (idTaken |=> state_q == SEQ_DATA && txKind == TX_DATA) // RULE1
		else $error("id not followed by its data");
	phase_len_a: assert property ((state_q == SEQ_DATA && $past(state_q) != SEQ_IDLE) ##1 state_q == SEQ_PH3 // RULE2
		|-> $past(nib_q) == (ctrl_q[`PSID_CTRL_EXT] ? `PSID_NIB_EXT_LAST : `PSID_NIB_STD_LAST))
		else $error("phase 2 ended at wrong nibble");
	sel_nib_a: assert property (idTaken and nib_q == `PSID_NIB_SEL19 and sel19_q // RULE4
		|=> dataNib_q == $past(serPart_q[7:4]))
		else $error("nibble 19 not from serial byte four");
	async_zero_a: assert property (idTaken and asyncEn and extEn and nib_q == `PSID_NIB_RES_FIRST // RULE10
		|=> dataNib_q == 4'h0)
		else $error("async extended nibble 33 not zero");
	rsvd_const_a: assert property (idTaken and nib_q > `PSID_NIB_RES_END |=> dataNib_q == `PSID_RSVD_VALUE) // RULE11
		else $error("reserved nibble not constant");
	st_start_a: assert property (state_q == SEQ_IDLE && phase1Done |-> ##[1:2] stRunReq) // RULE12
		else $error("self-test not started after phase 1");
	busy_msg_a: assert property (state_q == SEQ_PH3 && !stDone |-> txValid && txKind == TX_BUSY) // RULE15
		else $error("no busy message while self-test runs");
	// the second ready may be taken at once, so only the cycle after the first is pinned
	two_ready_a: assert property (state_q == SEQ_PH3 && accept && stDone && !ready_q // RULE16
		|=> state_q == SEQ_PH3 && ready_q)
		else $error("left phase 3 after one ready message");
	done_flag_a: assert property (state_q == SEQ_DONE |=> initDoneFlag && !txValid) // RULE17
		else $error("done flag not set on leaving phase 3");
endmodule : psid_sequencer

// File: verif/psid_rx_model.sv
// receiver-side model: takes transmissions, stalling when told, and reports each one taken
`timescale 1ns/1ns
module psid_rx_model (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               stall,   // hold-off request for the next cycle
	input  wire logic               txValid, // transmission pending
	input  wire psid_pkg::psid_tx_t txKind,  // id, data, busy or ready
	input  wire logic [5:0]         txData,  // index or nibble
	output logic                    txReady, // we take it
	output logic                    gotStb,  // an item was taken at the last edge
	output logic [7:0]              gotItem  // kind and data of that item
);
	import psid_pkg::*;
	// ready is registered, so a stall never changes it inside a cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txReady <= 1'b0;
		end else begin
			txReady <= !stall;
		end
	end
	// capture exactly what crossed at the accepting edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gotStb  <= 1'b0;
			gotItem <= 8'h00;
		end else begin
			gotStb  <= txValid & txReady;
			gotItem <= {txKind, txData};
		end
	end
endmodule : psid_rx_model

// File: verif/psid_init_data_sequencer_test.sv
// self-checking bench for the init sequencer: bus, self-test core stand-in and receiver
`timescale 1ns/1ns
`include "psid_consts.svh"
module psid_init_data_sequencer_test;
	import psid_pkg::*;
	logic        clk = 1'b0, rst = 1'b1;            // clock and async reset
	logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
	logic [5:0]  wbAdr = 6'h00;
	logic [3:0]  wbSel = 4'h0;
	logic [31:0] wbDat = 32'h0, stResult = 32'h0, wbDatO;
	logic        wbAck, stRunReq, txValid, txReady, initDoneFlag, irq, gotStb;
	logic        phase1Done = 1'b0, stRunDone = 1'b0, stRunPass = 1'b0;
	logic        rxStall = 1'b0, slowMode = 1'b0; // receiver hold-off control
	psid_tx_t    txKind;
	logic [5:0]  txData;
	logic [7:0]  gotItem;
	logic [7:0]  txQ[$];        // expected transmissions, oldest first
	logic [63:0] rdQ[$];        // expected read data and compare mask
	logic [48:0] runQ[$];       // pass, delay, result of each self-test run
	logic [48:0] run;           // run being answered
	logic [63:0] rdE;           // read expectation in use
	logic [31:0] uA, uB, sn, sp, res, r0, r1;
	logic        sel, aext;     // nibble 19/20 select, async with extended phase
	int          nFail = 0, samplesChecked = 0, reqCnt = 0, busyCnt = 0;

	// 10 ns period
	always #5 clk = ~clk;

	psid_sequencer dut_u (.clk(clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
		.phase1Done(phase1Done), .stRunReq(stRunReq), .stRunDone(stRunDone), .stRunPass(stRunPass),
		.stResult(stResult), .txValid(txValid), .txReady(txReady), .txKind(txKind), .txData(txData),
		.initDoneFlag(initDoneFlag), .irq(irq));

	psid_rx_model rx_u (.clk(clk), .rst(rst), .stall(rxStall), .txValid(txValid), .txKind(txKind),
		.txData(txData), .txReady(txReady), .gotStb(gotStb), .gotItem(gotItem));

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nFail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	// one classic cycle; for a read, d is the expected data and m the bits compared
	task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d, input logic [31:0] m = 32'h0);
		int t;
		if (!we) rdQ.push_back({d, m});
		@(posedge clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe  <= we;
		wbAdr <= a;
		wbSel <= 4'hf;
		wbDat <= we ? d : $urandom;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (wbAck !== 1'b1 && t < 100);
		// ack sampled high at this rising edge: only now is the request released
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (t >= 100) chk("bus ack", 32'h0, 32'h1);
	endtask : wb

	// expected nibble for a given index under the current settings
	function automatic logic [3:0] nib(input int n);
		if (n >= 10 && n <= 14) return uA[(n-10)*4 +: 4];
		if (n == 15 || n == 16) return uA[(n-9)*4 +: 4];
		if (n == 17 || n == 18) return uB[(n-17)*4 +: 4];
		if (n >= 21 && n <= 28) return sn[(28-n)*4 +: 4];
		if (n >= 33 && n <= 40) return (aext && n < 35) ? 4'h0 : res[(40-n)*4 +: 4];
		case (n)
			19: return sel ? sp[7:4] : uA[23:20];
			20: return sel ? sp[3:0] : uB[15:12];
			29: return sp[19:16];
			30: return sp[15:12];
			31: return sp[11:8];
			32: return uA[23:20];
			default: return `PSID_RSVD_VALUE;
		endcase
	endfunction : nib

	// one complete init: reset, configure, queue the expected stream, wait for the done flag
	task automatic runSeq(input logic [31:0] ctrl, input logic s, input logic slow, input int nRun,
		input logic [31:0] fieldTen);
		int t;
		int k;
		@(posedge clk);
		rst <= 1'b1;
		phase1Done <= 1'b0;
		@(posedge clk);
		rst <= 1'b0;
		slowMode <= slow;
		uA = $urandom;
		uB = $urandom;
		sn = $urandom;
		sp = $urandom;
		sel = s;
		aext = ctrl[0] & ctrl[1];
		res = fieldTen;
		busyCnt = 0;
		reqCnt = 0;
		wb(1'b1, `PSID_ADR_CTRL, ctrl);
		wb(1'b1, `PSID_ADR_TIMING2, {31'h0, s});
		wb(1'b1, `PSID_ADR_USERA, uA);
		wb(1'b1, `PSID_ADR_USERB, uB);
		wb(1'b1, `PSID_ADR_SERIAL, sn);
		wb(1'b1, `PSID_ADR_SERPART, sp);
		wb(1'b1, `PSID_ADR_MASK, 32'h0);
		// repetition zero behaves as one
		k = (ctrl[11:8] == 4'h0) ? 1 : int'(ctrl[11:8]);
		for (int n = 10; n <= (ctrl[0] ? 48 : 32); n++) begin
			repeat (k) begin
				txQ.push_back({TX_ID, 6'(n)});
				txQ.push_back({TX_DATA, 2'b00, nib(n)});
			end
		end
		txQ.push_back({TX_READY, 6'h00});
		txQ.push_back({TX_READY, 6'h00});
		phase1Done <= 1'b1;
		t = 0;
		do begin
			@(negedge clk);
			t++;
		end while (initDoneFlag !== 1'b1 && t < 20000);
		repeat (20) @(negedge clk);
		chk("items left", txQ.size(), 32'h0);
		chk("self-test runs", reqCnt, nRun);
		chk("done flag", initDoneFlag, 32'h1);
	endtask : runSeq

	// receiver may stall at random in slow mode
	always @(posedge clk) rxStall <= slowMode && ($urandom_range(1) == 1);

	// self-test core stand-in: answers each run request after the queued delay
	always @(negedge clk) begin
		if (stRunReq === 1'b1) begin
			reqCnt++;
			if (runQ.size() == 0) begin
				chk("extra run", 32'h1, 32'h0);
			end else begin
				run = runQ.pop_front();
				repeat (run[47:32]) @(posedge clk);
				stRunPass <= run[48];
				stResult  <= run[31:0];
				stRunDone <= 1'b1;
				@(posedge clk);
				stRunDone <= 1'b0;
			end
		end
	end

	// stream monitor: busy only ahead of the two readies, everything else in order
	always @(negedge clk) begin
		if (gotStb === 1'b1) begin
			if (gotItem[7:6] === TX_BUSY) begin
				busyCnt++;
				chk("busy place", (txQ.size() <= 2) ? 32'h1 : 32'h0, 32'h1);
			end else if (txQ.size() == 0) begin
				chk("extra item", 32'h1, 32'h0);
			end else begin
				chk("tx item", gotItem, txQ.pop_front());
			end
		end
	end

	// read monitor: takes read data at the rising edge where the master sees ack
	always @(posedge clk) begin
		if (wbCyc === 1'b1 && wbAck === 1'b1 && wbWe === 1'b0) begin
			rdE = rdQ.pop_front();
			chk("read data", wbDatO & rdE[31:0], rdE[63:32]);
		end
	end

	// hang guard, well beyond the longest sequence
	initial begin
		repeat (40000) @(posedge clk);
		nFail++;
		results();
	end

	initial begin
		void'($urandom(65453));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, `PSID_ADR_CTRL, 32'h0000_0430, 32'hffff_ffff);
		wb(1'b1, 6'h3c, 32'hffff_ffff);
		wb(1'b0, 6'h3c, 32'h0, 32'hffff_ffff);
		// sync, extended, one retry, both runs fail early: last failure in field ten
		r0 = $urandom;
		r1 = $urandom;
		runQ = '{{1'b0, 16'd3, r0}, {1'b0, 16'd3, r1}};
		runSeq(32'h0000_0111, 1'b1, 1'b0, 2, r1);
		chk("irq masked", irq, 32'h0);
		wb(1'b1, `PSID_ADR_MASK, 32'h8);
		@(negedge clk);
		chk("irq raised", irq, 32'h1);
		wb(1'b0, `PSID_ADR_STATUS, 32'h0000_0c0d, 32'h0000_1c0f);
		@(negedge clk);
		chk("irq cleared", irq, 32'h0);
		wb(1'b1, `PSID_ADR_RESULT, 32'h0);
		wb(1'b0, `PSID_ADR_RESULT, r1, 32'hffff_ffff);
		// async, extended, k two, stalls: pass lands in phase three, field ten uses first result
		r0 = $urandom;
		r1 = $urandom;
		runQ = '{{1'b0, 16'd3, r0}, {1'b1, 16'd1500, r1}};
		runSeq(32'h0000_0223, 1'b0, 1'b1, 2, r0);
		chk("busy sent", (busyCnt > 0) ? 32'h1 : 32'h0, 32'h1);
		// the early failed run leaves its sticky fail bit beside the pass
		wb(1'b0, `PSID_ADR_STATUS, 32'h0000_1c0f, 32'h0000_1c0f);
		// plain 32 nibbles, repetition zero, no retries
		runQ = '{{1'b1, 16'd3, r0}};
		runSeq(32'h0000_0000, 1'b1, 1'b0, 1, r0);
		// sync, extended, k four, stalls: first run passes before nibble 33, final results sent
		runQ = '{{1'b1, 16'd3, r1}};
		runSeq(32'h0000_0401, 1'b0, 1'b1, 1, r1);
		wb(1'b0, `PSID_ADR_STATUS, 32'h0000_1c0b, 32'h0000_1c0f);
		results();
	end
endmodule : psid_init_data_sequencer_test
